/* src/sdpd_core.sv */
// Divider chain, reference divider, phase detector, lock detector and register file.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none

module sdpd_core
  import sdpd_pkg::*;
(
  input  wire logic          core_clk,          // System clock, 20 MHz.
  input  wire logic          sys_rst,           // Asynchronous reset, active high.
  input  wire sdpd_bus_req_s bus_req,           // Register request.
  output logic [7:0]         bus_rdata,         // Read data, cycle after read strobe.
  input  wire logic          rf_in,             // Amplified RF input pin.
  input  wire logic          xtal_in,           // Crystal oscillator input pin.
  input  wire logic          hw_sleep_n,        // Hardware power-down pin, active low.
  input  wire logic          power_dip,         // Supply dip detector input pin.
  output sdpd_pump_s         pump,              // Charge pump controls.
  output logic               xtal_eighth_out,   // Crystal clock divided by eight.
  output logic               switch_out_a_o,    // Open-collector A drive level.
  output logic               switch_out_a_oe_n, // Low while A is pulled low.
  output logic               switch_out_b_o,    // Open-collector B drive level.
  output logic               switch_out_b_oe_n, // Low while B is pulled low.
  output logic               alarm_pin_o,       // Open-collector alarm drive level.
  output logic               alarm_pin_oe_n     // Low while the alarm is pulled low.
);

  function automatic logic [REF_W-1:0] ref_ratio_of(input logic [3:0] sel);
    ref_ratio_of = REF_RATIO[sel];
  endfunction : ref_ratio_of

  // Pin synchronisers: stage one feeds stage two only.
  logic [SYNC_N-1:0] pin_raw;
  logic [SYNC_N-1:0] sync1_q;
  logic [SYNC_N-1:0] sync2_q;
  logic [SYNC_N-1:0] sync3_q;
  assign pin_raw = {power_dip, hw_sleep_n, xtal_in, rf_in};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
        end
      end
    end
  endgenerate

  logic rf_edge;
  logic xtal_edge;
  logic sleep_now;
  logic dip_rise;
  assign rf_edge   = sync2_q[0] & ~sync3_q[0];
  assign xtal_edge = sync2_q[1] & ~sync3_q[1];
  assign sleep_now = ~sync2_q[2];
  assign dip_rise  = sync2_q[3] & ~sync3_q[3];

  // Register file; every register stays writable in power-down.
  logic [7:0] reg_a_q;
  logic [7:0] reg_b_q;
  logic [7:0] reg_c_q;
  logic [7:0] reg_d_q;
  logic       wr_a;
  logic       wr_b;
  logic       wr_c;
  logic       wr_d;
  logic       rd_status;
  assign wr_a      = bus_req.wr & (bus_req.addr == OFS_REG_A);
  assign wr_b      = bus_req.wr & (bus_req.addr == OFS_REG_B);
  assign wr_c      = bus_req.wr & (bus_req.addr == OFS_REG_C);
  assign wr_d      = bus_req.wr & (bus_req.addr == OFS_REG_D);
  assign rd_status = bus_req.rd & (bus_req.addr == OFS_STATUS);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_a_q <= RST_REG_A;
      reg_b_q <= RST_REG_B;
      reg_c_q <= RST_REG_C;
      reg_d_q <= RST_REG_D;
    end else begin
      if (wr_a) reg_a_q <= bus_req.wdata; // [R24]
      if (wr_b) reg_b_q <= bus_req.wdata; // [R24]
      if (wr_c) reg_c_q <= bus_req.wdata; // [R24]
      if (wr_d) reg_d_q <= bus_req.wdata; // [R24]
    end
  end

  logic pwr_down;
  assign pwr_down = reg_a_q[A_PWR_DOWN] | sleep_now; // [R21] [R22]

  // Ratio latch. Only a write of the low byte arms the transfer, so B and C may be written first in any order.
  logic [RATIO_W-1:0] ratio_new;
  logic [RATIO_W-1:0] ratio_fix;
  logic [RATIO_W-1:0] latch_q;
  logic [RATIO_W-1:0] act_q;
  logic               pend_q;
  assign ratio_new = {reg_b_q[B_RATIO_HI:0], reg_c_q, bus_req.wdata}; // [R3] [R4]
  assign ratio_fix = (ratio_new < RATIO_FLOOR) ? (ratio_new | RATIO_FLOOR) : ratio_new; // [R7] [R8]

  // Pulse-swallow divider. Main counter runs N..0, so N+1 prescaler cycles per output.
  // The prescaler uses 32 while main + swallow >= 32, else 31, which sums to 32N+R.
  logic [PRESC_W-1:0]   presc_q;
  logic [MAIN_W-1:0]    main_q;
  logic [MAIN_W-1:0]    n_act;
  logic [SWALLOW_W-1:0] r_act;
  logic [MAIN_W:0]      mod_sum;
  logic [PRESC_W-1:0]   presc_top;
  logic                 presc_wrap;
  logic                 var_pulse;
  assign n_act      = act_q[RATIO_W-1:SWALLOW_W]; // [R2]
  assign r_act      = act_q[SWALLOW_W-1:0]; // [R2]
  assign mod_sum    = {1'b0, main_q} + {{(MAIN_W-SWALLOW_W+1){1'b0}}, r_act};
  assign presc_top  = (mod_sum >= SWALLOW_THR) ? PRESC_TOP_32 : PRESC_TOP_31; // [R1]
  assign presc_wrap = rf_edge & ~pwr_down & (presc_q == presc_top);
  assign var_pulse  = presc_wrap & (main_q == '0); // [R26]

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      latch_q <= '0;
      pend_q  <= 1'b0;
    end else if (wr_d) begin
      latch_q <= ratio_fix; // [R5]
      pend_q  <= 1'b1; // [R5] [R9]
    end else if (var_pulse | pwr_down) begin
      pend_q  <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_q   <= RATIO_FLOOR;
      presc_q <= '0;
      main_q  <= '0;
    end else if (pwr_down) begin
      // Preload a full count so the first output after wake-up spans a whole ratio, not one prescaler cycle.
      if (pend_q) act_q <= latch_q;
      presc_q <= '0;
      main_q  <= pend_q ? latch_q[RATIO_W-1:SWALLOW_W] : n_act; // [R26]
    end else if (rf_edge) begin
      if (presc_wrap) begin
        presc_q <= '0; // [R1]
        if (main_q == '0) begin
          if (pend_q) begin
            act_q  <= latch_q; // [R6]
            main_q <= latch_q[RATIO_W-1:SWALLOW_W]; // [R6]
          end else begin
            main_q <= n_act;
          end
        end else begin
          main_q <= main_q - 1'b1; // [R1]
        end
      end else begin
        presc_q <= presc_q + 1'b1;
      end
    end
  end

  // Reference divider and crystal-over-eight output.
  logic [REF_W-1:0] ref_q;
  logic [REF_W-1:0] ref_top;
  logic             ref_pulse;
  logic [2:0]       eighth_q;
  assign ref_top   = ref_ratio_of(reg_a_q[A_REF_SEL_HI:0]) - 1'b1; // [R10] [R11]
  assign ref_pulse = xtal_edge & ~pwr_down & (ref_q >= ref_top);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_q    <= '0;
      eighth_q <= '0;
    end else begin
      if (xtal_edge) eighth_q <= eighth_q + 1'b1; // [R23]
      if (pwr_down) ref_q <= '0;
      else if (ref_pulse) ref_q <= '0; // [R10]
      else if (xtal_edge) ref_q <= ref_q + 1'b1;
    end
  end

  // Three-state detector: a leading reference edge opens the up state and a leading RF edge the down state.
  // Simultaneous edges cancel, which keeps the dead zone out of the loop.
  sdpd_pfd_e pfd_q;
  sdpd_pfd_e pfd_d;
  always_comb begin
    pfd_d = pfd_q;
    case (pfd_q)
      PFD_IDLE: begin
        if (ref_pulse & ~var_pulse) pfd_d = PFD_UP; // [R12]
        else if (var_pulse & ~ref_pulse) pfd_d = PFD_DOWN; // [R12]
      end
      PFD_UP: begin
        if (var_pulse) pfd_d = PFD_IDLE;
      end
      PFD_DOWN: begin
        if (ref_pulse) pfd_d = PFD_IDLE;
      end
      default: pfd_d = PFD_IDLE;
    endcase
    if (pwr_down) pfd_d = PFD_IDLE; // [R21]
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) pfd_q <= PFD_IDLE;
    else pfd_q <= pfd_d;
  end

  logic fast_ref;
  logic slow_ref;
  logic polarity;
  assign fast_ref = (pfd_q == PFD_UP);
  assign slow_ref = (pfd_q == PFD_DOWN);
  assign polarity = reg_b_q[B_POLARITY];

  sdpd_pump_s pump_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pump_q <= '{up: 1'b0, down: 1'b0, oe_n: 1'b1, hi_current: 1'b0};
    end else begin
      pump_q.up         <= polarity ? slow_ref : fast_ref; // [R15] [R16]
      pump_q.down       <= polarity ? fast_ref : slow_ref; // [R15] [R16]
      pump_q.oe_n       <= ~(fast_ref | slow_ref); // [R13]
      pump_q.hi_current <= reg_a_q[A_PUMP_CUR]; // [R14]
    end
  end
  assign pump = pump_q;

  // Lock detector: error width counted in core cycles, good reference periods counted to release.
  logic [2:0] err_q;
  logic [2:0] good_q;
  logic       big_err_q;
  logic       unlock_q;
  logic       err_active;
  logic       err_over;
  assign err_active = fast_ref | slow_ref; // [R17]
  assign err_over   = err_active & (err_q >= 3'(PHASE_ERR_CYC)); // [R19]

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_q     <= '0;
      good_q    <= '0;
      big_err_q <= 1'b0;
      unlock_q  <= 1'b0;
    end else begin
      if (!err_active) err_q <= '0;
      else if (!err_over) err_q <= err_q + 1'b1;
      if (err_over) begin
        unlock_q  <= 1'b1; // [R19]
        good_q    <= '0;
        big_err_q <= 1'b1;
      end else if (ref_pulse) begin
        big_err_q <= 1'b0;
        if (!big_err_q) begin
          if (good_q >= 3'(GOOD_REF_CYC - 1)) unlock_q <= 1'b0; // [R20]
          else good_q <= good_q + 1'b1;
        end else begin
          good_q <= '0; // [R20]
        end
      end
    end
  end

  // Alarm and latched status bits; a new event in the reading cycle wins over the clear.
  logic unlock_rise;
  logic unlock_dly_q;
  logic unlock_lat_q;
  logic dip_lat_q;
  assign unlock_rise = unlock_q & ~unlock_dly_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      unlock_dly_q <= 1'b0;
      unlock_lat_q <= 1'b0;
      dip_lat_q    <= 1'b0;
    end else begin
      unlock_dly_q <= unlock_q;
      if (unlock_rise) unlock_lat_q <= 1'b1; // [R25]
      else if (rd_status) unlock_lat_q <= 1'b0; // [R25]
      if (dip_rise) dip_lat_q <= 1'b1; // [R25]
      else if (rd_status) dip_lat_q <= 1'b0; // [R25]
    end
  end

  logic [7:0] status;
  always_comb begin
    status                = 8'h00;
    status[ST_UNLOCK_NOW] = unlock_q; // [R18]
    status[ST_UNLOCK_LAT] = unlock_lat_q;
    status[ST_DIP_LAT]    = dip_lat_q;
  end

  logic [7:0] rsel;
  logic [7:0] rdata_q;
  assign rsel = (bus_req.addr == OFS_REG_A)  ? reg_a_q :
                (bus_req.addr == OFS_REG_B)  ? reg_b_q :
                (bus_req.addr == OFS_REG_C)  ? reg_c_q :
                (bus_req.addr == OFS_REG_D)  ? reg_d_q :
                (bus_req.addr == OFS_STATUS) ? status  : 8'h00;

  logic sw_a_q;
  logic sw_b_q;
  logic alarm_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
      sw_a_q  <= 1'b0;
      sw_b_q  <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      rdata_q <= bus_req.rd ? rsel : 8'h00;
      sw_a_q  <= unlock_q | ~reg_b_q[B_SWITCH_A]; // [R17]
      sw_b_q  <= ~reg_b_q[B_SWITCH_B];
      alarm_q <= unlock_lat_q | dip_lat_q; // [R25]
    end
  end

  assign bus_rdata         = rdata_q;
  assign xtal_eighth_out   = eighth_q[2]; // [R23]
  assign switch_out_a_o    = 1'b0;
  assign switch_out_a_oe_n = ~sw_a_q; // [R17]
  assign switch_out_b_o    = 1'b0;
  assign switch_out_b_oe_n = ~sw_b_q;
  assign alarm_pin_o       = 1'b0;
  assign alarm_pin_oe_n    = ~alarm_q; // [R25]

endmodule : sdpd_core

`default_nettype wire

/* src/sdpd_pkg.sv */
// Constants, types and register map of the synthesizer divider and phase detector core.
// Summary of operation
// [R1] Prescaler 31/32 clocks 5-bit swallow, 13-bit main counter.
// [R2] Swallow takes low five bits, main takes upper thirteen.
// [R3] Ratio held in 18-bit latch from registers B, C, D.
// [R4] Ratio order: B[1:0], then C, then D.
// [R5] New ratio loads only after register D written.
// [R6] Ratio transfer aligned to divider output pulse.
// [R7] Main divider supports ratios 2048 to 262143.
// [R8] Ratio below 2048 divides by value plus 2048.
// [R9] Host may rewrite only D for adjacent channels.
// [R10] Reference divider offers 16 ratios via ref_ratio_sel.
// [R11] Codes map in order 128 up to 1920.
// [R12] Phase-frequency detector drives up or down on error.
// [R13] No error: both currents off, pump output floats.
// [R14] pump_current_select bit 5 chooses 1 mA or 0.5 mA.
// [R15] comparator_polarity inverts the up and down sense.
// [R16] Polarity 0: slow reference gives down, fast gives up.
// [R17] Unlock from up/down drives switch_out_a low.
// [R18] unlock_now_flag mirrors momentary unlock in status.
// [R19] Unlock flagged at once above 200 ns error.
// [R20] Unlock clears after six good reference cycles.
// [R21] Power-down stops synthesizer, registers stay accessible.
// [R22] Low hw_sleep_n forces power-down.
// [R23] xtal_eighth_out is crystal frequency divided by eight.
// [R24] Control part stores bytes in four 8-bit registers.
// [R25] Unlock or power dip latches alarm_pin low until read.
// [R26] Overall ratio equals the 18-bit binary value.
package sdpd_pkg;

  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PHASE_ERR_NS  = 200;
  localparam int unsigned PHASE_ERR_CYC = (PHASE_ERR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GOOD_REF_CYC  = 6;

  localparam logic [2:0] OFS_REG_A  = 3'h0;
  localparam logic [2:0] OFS_REG_B  = 3'h1;
  localparam logic [2:0] OFS_REG_C  = 3'h2;
  localparam logic [2:0] OFS_REG_D  = 3'h3;
  localparam logic [2:0] OFS_STATUS = 3'h4;

  localparam logic [7:0] RST_REG_A = 8'h0E;
  localparam logic [7:0] RST_REG_B = 8'hA5;
  localparam logic [7:0] RST_REG_C = 8'h38;
  localparam logic [7:0] RST_REG_D = 8'h80;

  localparam int unsigned A_PWR_DOWN   = 7;
  localparam int unsigned A_PUMP_CUR   = 5;
  localparam int unsigned A_REF_SEL_HI = 3;
  localparam int unsigned B_POLARITY   = 4;
  localparam int unsigned B_SWITCH_B   = 3;
  localparam int unsigned B_SWITCH_A   = 2;
  localparam int unsigned B_RATIO_HI   = 1;

  localparam int unsigned ST_UNLOCK_NOW = 4;
  localparam int unsigned ST_UNLOCK_LAT = 2;
  localparam int unsigned ST_DIP_LAT    = 1;

  localparam int unsigned RATIO_W    = 18;
  localparam int unsigned SWALLOW_W  = 5;
  localparam int unsigned MAIN_W     = 13;
  localparam int unsigned REF_W      = 11;
  localparam int unsigned PRESC_W    = 5;
  localparam int unsigned SYNC_N     = 4;
  localparam logic [RATIO_W-1:0] RATIO_FLOOR = 18'h00800;
  localparam logic [4:0] PRESC_TOP_32 = 5'h1F;
  localparam logic [4:0] PRESC_TOP_31 = 5'h1E;
  localparam logic [MAIN_W:0] SWALLOW_THR = 14'h0020;

  localparam logic [REF_W-1:0] REF_RATIO [16] = '{
    11'h080, 11'h0A0, 11'h0C0, 11'h0F0, 11'h100, 11'h140, 11'h180, 11'h1E0,
    11'h200, 11'h280, 11'h300, 11'h3C0, 11'h400, 11'h500, 11'h600, 11'h780};

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sdpd_bus_req_s;

  typedef struct packed {
    logic up;
    logic down;
    logic oe_n;
    logic hi_current;
  } sdpd_pump_s;

  typedef enum logic [1:0] {
    PFD_IDLE = 2'b00,
    PFD_UP   = 2'b01,
    PFD_DOWN = 2'b10
  } sdpd_pfd_e;

endpackage : sdpd_pkg

/* verif/sdpd_core_monitor.sv */
// Checker of bus, pump, switch and alarm behaviour at the core's ports.
`timescale 1ns/10ps
`default_nettype none

module sdpd_core_chk
  import sdpd_pkg::*;
(
  input wire logic          core_clk,          // Clock.
  input wire logic          sys_rst,           // Reset.
  input wire sdpd_bus_req_s bus_req,           // Register request.
  input wire logic [7:0]    bus_rdata,         // Read data.
  input wire logic          hw_sleep_n,        // Sleep pin.
  input wire logic          power_dip,         // Dip pin.
  input wire sdpd_pump_s    pump,              // Pump controls.
  input wire logic          switch_out_a_oe_n, // Switch A enable.
  input wire logic          alarm_pin_oe_n     // Alarm enable.
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_st_rd;
    bus_req.rd && bus_req.addr == OFS_STATUS ##1 1'b1;
  endsequence

  property p_rd_idle;
    !$past(bus_req.rd) |-> bus_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_unmap;
    $past(bus_req.rd) && $past(bus_req.addr) > OFS_STATUS |-> bus_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_st_zero;
    s_st_rd |-> (bus_rdata & 8'hE9) == 8'h00;
  endproperty
  a_st_zero: assert property (p_st_zero) else $error("unused status bits set");
  property p_float;
    pump.oe_n == !(pump.up || pump.down);
  endproperty
  a_float: assert property (p_float) else $error("pump drive without error");
  property p_excl;
    !(pump.up && pump.down);
  endproperty
  a_excl: assert property (p_excl) else $error("up and down together");
  property p_cur;
    bus_req.wr && bus_req.addr == OFS_REG_A ##1 (!(bus_req.wr && bus_req.addr == OFS_REG_A)) [*2]
      |-> pump.hi_current == $past(bus_req.wdata[A_PUMP_CUR], 2);
  endproperty
  a_cur: assert property (p_cur) else $error("pump current select wrong");
  property p_sleep;
    !hw_sleep_n [*6] |-> pump.oe_n;
  endproperty
  a_sleep: assert property (p_sleep) else $error("pump active in sleep");
  property p_swa;
    s_st_rd ##0 bus_rdata[ST_UNLOCK_NOW] |-> !switch_out_a_oe_n;
  endproperty
  a_swa: assert property (p_swa) else $error("switch A not low on unlock");
  property p_alarm_st;
    s_st_rd ##0 (bus_rdata[ST_UNLOCK_LAT] || bus_rdata[ST_DIP_LAT]) |-> !alarm_pin_oe_n;
  endproperty
  a_alarm_st: assert property (p_alarm_st) else $error("alarm released while latched");
  property p_alarm_rel;
    $rose(alarm_pin_oe_n) |-> $past(bus_req.rd && bus_req.addr == OFS_STATUS, 2);
  endproperty
  a_alarm_rel: assert property (p_alarm_rel) else $error("alarm released without read");
  property p_dip;
    $rose(power_dip) |-> ##[1:6] !alarm_pin_oe_n;
  endproperty
  a_dip: assert property (p_dip) else $error("dip did not pull alarm");
endmodule : sdpd_core_chk

bind sdpd_core sdpd_core_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .hw_sleep_n(hw_sleep_n), .power_dip(power_dip), .pump(pump),
  .switch_out_a_oe_n(switch_out_a_oe_n), .alarm_pin_oe_n(alarm_pin_oe_n));

`default_nettype wire

/* verif/sdpd_vco_model.sv */
// Model of the external VCO and crystal source that drive the RF and crystal pins.
`timescale 1ns/10ps
`default_nettype none

module sdpd_vco_model (
  input  wire logic core_clk, // Bench clock.
  input  wire logic rf_run,   // RF oscillates while high.
  input  wire logic xtal_run, // Crystal oscillates while high.
  output logic      rf_in,    // RF pin.
  output logic      xtal_in   // Crystal pin.
);
  logic [2:0] rf_ph_q = 3'h0;
  logic [1:0] xt_ph_q = 2'h0;

  // RF runs at a fifth of the clock, slower than the core's half-rate limit; idle pins rest low.
  always @(posedge core_clk) begin
    rf_ph_q <= (rf_ph_q == 3'h4) ? 3'h0 : rf_ph_q + 3'h1;
    xt_ph_q <= xt_ph_q + 2'h1;
    rf_in   <= rf_run && (rf_ph_q < 3'h3);
    xtal_in <= xtal_run && xt_ph_q[1];
  end
endmodule : sdpd_vco_model

`default_nettype wire

/* verif/synth_divider_phase_detect_tb.sv */
// Self-checking bench of the divider and phase detector core.
`timescale 1ns/10ps
`default_nettype none

module synth_divider_phase_detect_tb
  import sdpd_pkg::*;
;
  logic          core_clk, sys_rst, hw_sleep_n, power_dip, rf_run, xtal_run, rf_in, xtal_in;
  logic          xtal_eighth_out, sw_a_oe_n, sw_b_oe_n, alarm_oe_n;
  logic [7:0]    rv;
  logic [7:0]    bus_rdata;
  logic [7:0]    rst_v [4] = '{RST_REG_A, RST_REG_B, RST_REG_C, RST_REG_D};
  sdpd_bus_req_s bus_req;
  sdpd_pump_s    pump;
  int            err_count = 0, check_count = 0, cyc = 0, rf_cnt = 0, xt_cnt = 0, n, a, r;

  sdpd_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .rf_in(rf_in), .xtal_in(xtal_in), .hw_sleep_n(hw_sleep_n), .power_dip(power_dip), .pump(pump),
    .xtal_eighth_out(xtal_eighth_out), .switch_out_a_o(), .switch_out_a_oe_n(sw_a_oe_n),
    .switch_out_b_o(), .switch_out_b_oe_n(sw_b_oe_n), .alarm_pin_o(), .alarm_pin_oe_n(alarm_oe_n));
  sdpd_vco_model u_vco (.core_clk(core_clk), .rf_run(rf_run), .xtal_run(xtal_run), .rf_in(rf_in),
    .xtal_in(xtal_in));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge rf_in) rf_cnt++;
  always @(posedge xtal_in) xt_cnt++;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      finish_test();
    end
  end

  function automatic int ref_div(input logic [3:0] c);
    return (c[1:0] == 2'h3 ? 240 : 128 + 32 * c[1:0]) << c[3:2];
  endfunction : ref_div

  task automatic finish_test();
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    bus_req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [2:0] ad);
    bus_req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    @(negedge core_clk);
    rv = bus_rdata;
    @(posedge core_clk);
  endtask : rd

  // Ends at a falling edge so the caller samples settled pump outputs.
  task automatic wait_pump();
    n = 0;
    while (pump.oe_n !== 1'b0 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_pump

  // The divider restarts on leaving power-down, so the first pulse comes after one full ratio.
  task automatic ratio_run(input int exp);
    wr(OFS_REG_A, 8'h00);
    rf_cnt = 0;
    rf_run <= 1'b1;
    wait_pump();
    check(pump.down, 1'b1);
    check(((rf_cnt - exp) inside {[-3:3]}), 1'b1);
    @(posedge core_clk);
    rf_run <= 1'b0;
    wr(OFS_REG_A, 8'h80);
    repeat (6) @(negedge core_clk);
    check(pump.oe_n, 1'b1);
    @(posedge core_clk);
  endtask : ratio_run

  initial begin
    n = $urandom(98809);
    sys_rst = 1'b1;
    bus_req = '0;
    hw_sleep_n = 1'b1;
    power_dip = 1'b0;
    rf_run = 1'b0;
    xtal_run = 1'b0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (a = 0; a < 8; a++) begin
      rd(a[2:0]);
      check(rv, a < 4 ? rst_v[a] : 8'h00);
    end
    check(sw_b_oe_n, 1'b0);
    repeat (4) begin
      n = $urandom;
      wr(OFS_REG_C, n[7:0]);
      wr(OFS_REG_D, n[15:8]);
      wr(OFS_STATUS, n[23:16]);
      rd(OFS_REG_C);
      check(rv, n[7:0]);
      rd(OFS_REG_D);
      check(rv, n[15:8]);
      rd(OFS_STATUS);
      check(rv, 8'h00);
    end
    wr(OFS_REG_A, 8'h80);
    wr(OFS_REG_B, 8'hA4);
    wr(OFS_REG_C, 8'h00);
    wr(OFS_REG_D, 8'h05);
    ratio_run(2053);
    wr(OFS_REG_C, 8'h08);
    ratio_run(2053);
    r = $urandom % 64;
    wr(OFS_REG_D, r[7:0]);
    ratio_run(2048 + r);
    for (a = 0; a < 16; a++) begin
      if (a == 15) wr(OFS_REG_B, 8'hB4);
      wr(OFS_REG_A, {2'h0, a[0], 1'b0, a[3:0]});
      xt_cnt = 0;
      xtal_run <= 1'b1;
      wait_pump();
      check(a == 15 ? pump.down : pump.up, 1'b1);
      check(pump.hi_current, a[0]);
      check(((xt_cnt - ref_div(a[3:0])) inside {[-3:3]}), 1'b1);
      if (a == 0) begin
        repeat (8) @(negedge core_clk);
        check(sw_a_oe_n, 1'b0);
        @(posedge core_clk);
        rd(OFS_STATUS);
        check(rv, 8'h14);
        repeat (4) @(negedge core_clk);
        check(alarm_oe_n, 1'b1);
        @(xtal_eighth_out);
        @(negedge core_clk);
        n = xt_cnt;
        @(xtal_eighth_out);
        @(negedge core_clk);
        check(xt_cnt - n, 4);
      end
      @(posedge core_clk);
      xtal_run <= 1'b0;
      wr(OFS_REG_A, 8'h80);
    end
    wr(OFS_REG_A, 8'h00);
    xtal_run <= 1'b1;
    wait_pump();
    @(posedge core_clk);
    hw_sleep_n <= 1'b0;
    repeat (8) @(negedge core_clk);
    check(pump.oe_n, 1'b1);
    @(posedge core_clk);
    rd(OFS_REG_D);
    check(rv, r[7:0]);
    power_dip <= 1'b1;
    repeat (3) @(posedge core_clk);
    power_dip <= 1'b0;
    repeat (6) @(negedge core_clk);
    check(alarm_oe_n, 1'b0);
    @(posedge core_clk);
    rd(OFS_STATUS);
    check(rv[ST_DIP_LAT], 1'b1);
    finish_test();
  end
endmodule : synth_divider_phase_detect_tb

`default_nettype wire
